/* inc/dimmer_pkg.sv */
package dimmer_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int OFF_TIMEOUT_US = 500;
	localparam int OFF_TIMEOUT_CYC = (CLK_HZ / 1000000) * OFF_TIMEOUT_US;
	localparam int SOFT_START_US = 400;
	localparam int SOFT_START_CYC = (CLK_HZ / 1000000) * SOFT_START_US;
	localparam int TMR_W = 16;

	// ----------------------------------------------------------------
	// Brightness code
	// ----------------------------------------------------------------
	localparam int CODE_W = 5;
	localparam int CUR_W = 15;
	localparam int LED_COUNT = 4;
	localparam logic [CODE_W-1:0] CODE_LOW = 5'h00;
	localparam logic [CODE_W-1:0] CODE_FULL = 5'h1F;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_SOFT,
		ST_ON
	} dim_state_e;

	typedef struct packed {
		logic active;
		logic soft_start;
		logic [CODE_W-1:0] code;
	} dim_status_s;

endpackage : dimmer_pkg

/* design/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	always_comb begin
		st_nxt.meta = pin_in;
		st_nxt.sync = st_r.meta;
		st_nxt.prev = st_r.sync;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.sync;
	assign rise_out = st_r.sync & ~st_r.prev;

endmodule : pin_sync
`default_nettype wire

/* design/current_rom.sv */
`timescale 1ns/1ps
`default_nettype none

module current_rom (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [dimmer_pkg::CODE_W-1:0] code_in,
	output logic [dimmer_pkg::CUR_W-1:0] microamp_out
);
	import dimmer_pkg::*;

	// ----------------------------------------------------------------
	// Table of output currents in microamps, code 1 at index 0
	// ----------------------------------------------------------------
	function automatic logic [CUR_W-1:0] lookup(input logic [CODE_W-1:0] idx);
		case (idx)
			5'h00: lookup = 15'h0225;
			5'h01: lookup = 15'h0273;
			5'h02: lookup = 15'h02C2;
			5'h03: lookup = 15'h0310;
			5'h04: lookup = 15'h035F;
			5'h05: lookup = 15'h03FC;
			5'h06: lookup = 15'h044A;
			5'h07: lookup = 15'h04E7;
			5'h08: lookup = 15'h0584;
			5'h09: lookup = 15'h0621;
			5'h0A: lookup = 15'h070C;
			5'h0B: lookup = 15'h07A9;
			5'h0C: lookup = 15'h08E3;
			5'h0D: lookup = 15'h09CE;
			5'h0E: lookup = 15'h0B08;
			5'h0F: lookup = 15'h0C41;
			5'h10: lookup = 15'h0DC9;
			5'h11: lookup = 15'h0FA0;
			5'h12: lookup = 15'h1177;
			5'h13: lookup = 15'h139C;
			5'h14: lookup = 15'h160F;
			5'h15: lookup = 15'h18D1;
			5'h16: lookup = 15'h1B93;
			5'h17: lookup = 15'h1EF2;
			5'h18: lookup = 15'h22ED;
			5'h19: lookup = 15'h2737;
			5'h1A: lookup = 15'h2BD0;
			5'h1B: lookup = 15'h3153;
			5'h1C: lookup = 15'h3726;
			5'h1D: lookup = 15'h3DE3;
			5'h1E: lookup = 15'h458C;
			default: lookup = 15'h4E20;
		endcase
	endfunction : lookup

	logic [CUR_W-1:0] data_r;
	logic [CUR_W-1:0] data_nxt;

	always_comb begin
		data_nxt = lookup(code_in);
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign microamp_out = data_r;

endmodule : current_rom
`default_nettype wire

/* design/pulse_count_led_dimmer.sv */
// Operation
// RQ1: Rising edges step one of 32 log codes.
// RQ2: Code 32 full scale, code 1 -31 dB.
// RQ3: Edge at code 32 wraps to code 1.
// RQ4: Each edge adds 1 dB; 31 lowers one.
// RQ5: Edges up to 1 MHz accepted.
// RQ6: First edge enables at lowest code.
// RQ7: Line held high keeps current steady.
// RQ8: Low for timeout disables, outputs off.
// RQ9: Edges still counted during soft start.
// RQ10: Host may space pulses below timeout.
// RQ11: Codes map to fixed current table.
// RQ12: One code drives all four outputs.
// RQ13: Timeout counter restarts; expiry resets code.
`timescale 1ns/1ps
`default_nettype none

module pulse_count_led_dimmer #(
	parameter int OFF_CYCLES = dimmer_pkg::OFF_TIMEOUT_CYC,
	parameter int SOFT_CYCLES = dimmer_pkg::SOFT_START_CYC
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic en_set_in,
	output logic [dimmer_pkg::CUR_W-1:0] led_out_one,
	output logic [dimmer_pkg::CUR_W-1:0] led_out_two,
	output logic [dimmer_pkg::CUR_W-1:0] led_out_three,
	output logic [dimmer_pkg::CUR_W-1:0] led_out_four,
	output dimmer_pkg::dim_status_s status_out
);
	import dimmer_pkg::*;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic line_level;
	logic line_rise;

	// A 1 MHz pulse train gives 20 cycles per level, ample for the sampler.
	pin_sync u_sync ( // RQ5
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.pin_in(en_set_in),
		.level_out(line_level),
		.rise_out(line_rise)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dim_state_e state;
		logic [CODE_W-1:0] code;
		logic [TMR_W-1:0] low_cnt;
		logic [TMR_W-1:0] soft_cnt;
		logic drive;
		logic drive_d;
	} core_s;

	core_s st_r;
	core_s st_nxt;

	localparam logic [TMR_W-1:0] OFF_LIMIT = TMR_W'(OFF_CYCLES - 1);
	localparam logic [TMR_W-1:0] SOFT_LIMIT = TMR_W'(SOFT_CYCLES - 1);
	localparam logic [CODE_W-1:0] CODE_STEP = 5'h01;

	always_comb begin
		st_nxt = st_r;
		// The enable trails by one cycle to line up with the registered table output.
		st_nxt.drive_d = st_r.drive;
		case (st_r.state)
			ST_OFF: begin
				st_nxt.drive = 1'b0;
				if (line_rise) begin
					st_nxt.state = ST_SOFT; // RQ6
					st_nxt.code = CODE_LOW; // RQ6 RQ2
					st_nxt.low_cnt = '0;
					st_nxt.soft_cnt = '0;
					st_nxt.drive = 1'b1;
				end
			end
			ST_SOFT, ST_ON: begin
				if (line_rise) begin
					// Wrapping from full scale back to code 1 falls out of 5-bit overflow.
					st_nxt.code = st_r.code + CODE_STEP; // RQ1 RQ3 RQ4 RQ9
				end
				if (st_r.state == ST_SOFT) begin
					if (st_r.soft_cnt >= SOFT_LIMIT) begin
						st_nxt.state = ST_ON;
					end else begin
						st_nxt.soft_cnt = st_r.soft_cnt + TMR_W'(1);
					end
				end
				if (line_level) begin
					st_nxt.low_cnt = '0; // RQ7 RQ13
				end else if (st_r.low_cnt >= OFF_LIMIT) begin
					st_nxt.state = ST_OFF; // RQ8 RQ13
					st_nxt.code = CODE_LOW;
					st_nxt.low_cnt = '0;
					st_nxt.soft_cnt = '0;
					st_nxt.drive = 1'b0;
				end else begin
					st_nxt.low_cnt = st_r.low_cnt + TMR_W'(1); // RQ10
				end
			end
			default: begin
				st_nxt.state = ST_OFF;
				st_nxt.drive = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			st_r <= '{state: ST_OFF, code: CODE_LOW, low_cnt: '0, soft_cnt: '0, drive: 1'b0,
				drive_d: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Current level
	// ----------------------------------------------------------------
	logic [CUR_W-1:0] level_ua;

	current_rom u_rom ( // RQ11
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.code_in(st_r.code),
		.microamp_out(level_ua)
	);

	logic [CUR_W-1:0] led_level [LED_COUNT];

	genvar g;
	generate
		for (g = 0; g < LED_COUNT; g++) begin : g_led
			assign led_level[g] = st_r.drive_d ? level_ua : '0; // RQ12 RQ8
		end
	endgenerate

	assign led_out_one = led_level[0];
	assign led_out_two = led_level[1];
	assign led_out_three = led_level[2];
	assign led_out_four = led_level[3];

	assign status_out = '{active: st_r.drive, soft_start: (st_r.state == ST_SOFT), code: st_r.code};

endmodule : pulse_count_led_dimmer
`default_nettype wire

/* testbench/dimmer_props.sv */
`timescale 1ns/1ps
`default_nettype none

module dimmer_props #(
	parameter int OFF_CYCLES = 50
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic en_set_in,
	input wire logic [dimmer_pkg::CUR_W-1:0] led_out_one,
	input wire logic [dimmer_pkg::CUR_W-1:0] led_out_four,
	input wire dimmer_pkg::dim_status_s status_out
);
	import dimmer_pkg::*;
	// Saturates so that a long idle never wraps back into range.
	logic [TMR_W-1:0] low_r;
	logic [TMR_W-1:0] low_nxt;
	always_comb low_nxt = en_set_in ? '0 : low_r + TMR_W'(low_r != '1);
	always_ff @(posedge clk_sys_in) low_r <= srst_in ? '0 : low_nxt;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	sequence s_rise; !en_set_in ##1 en_set_in; endsequence
	sequence s_full; (status_out.active && status_out.code == CODE_FULL) [*3]; endsequence
	chk_edge_taken: assert property (s_rise |-> ##[1:5]
		($changed(status_out.code) || $rose(status_out.active))) else $error("edge lost");
	chk_step_wrap: assert property (status_out.active && $past(status_out.active) &&
		$changed(status_out.code) |-> status_out.code == 5'($past(status_out.code) + 5'h01))
		else $error("bad step");
	chk_first_low: assert property ($rose(status_out.active) |->
		status_out.code == CODE_LOW && status_out.soft_start ##1 led_out_one == 15'h0225)
		else $error("bad enable");
	chk_hold_high: assert property (en_set_in [*8] |-> $stable(status_out.code))
		else $error("code moved");
	chk_full_scale: assert property (s_full |-> led_out_one == 15'h4E20)
		else $error("bad full");
	chk_leds_same: assert property (led_out_four == led_out_one)
		else $error("leds differ");
	chk_off_late: assert property ($fell(status_out.active) |->
		low_r >= OFF_CYCLES ##1 led_out_one == 15'h0000) else $error("early off");
	chk_off_due: assert property (low_r == OFF_CYCLES + 8 |->
		!status_out.active && status_out.code == CODE_LOW) else $error("no off");
endmodule : dimmer_props

bind pulse_count_led_dimmer dimmer_props #(.OFF_CYCLES(OFF_CYCLES)) u_props (.*);

`default_nettype wire

/* testbench/host_gpio.sv */
`timescale 1ns/1ps
`default_nettype none

module host_gpio (
	input wire logic clk_sys_in,
	output logic en_set_out
);
	initial en_set_out = 1'b0;
	// Each pulse leaves the line high, so the level is kept afterwards.
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			if (en_set_out) begin
				en_set_out = 1'b0;
				repeat (half) @(negedge clk_sys_in);
			end
			en_set_out = 1'b1;
			repeat (half) @(negedge clk_sys_in);
		end
	endtask : pulses
	task automatic idle(input int cyc);
		en_set_out = 1'b0;
		repeat (cyc) @(negedge clk_sys_in);
	endtask : idle
endmodule : host_gpio

`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dimmer_pkg::*;
	logic clk_sys_in;
	logic srst_in;
	logic en_set_in;
	logic [CUR_W-1:0] led_a, led_b, led_c, led_d;
	dim_status_s st;
	int error_cnt;
	int tests_run;
	pulse_count_led_dimmer #(.OFF_CYCLES(50), .SOFT_CYCLES(1400)) dut (.clk_sys_in,
		.srst_in, .en_set_in, .led_out_one(led_a), .led_out_two(led_b),
		.led_out_three(led_c), .led_out_four(led_d), .status_out(st));
	host_gpio host (.clk_sys_in, .en_set_out(en_set_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input logic [CUR_W-1:0] e, g, input string n);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %0d got %0d", n, e, g);
		end
	endtask : chk
	// Eight cycles clear the input sync and the output pipeline.
	task automatic lvl(input logic [4:0] c, input logic [CUR_W-1:0] ua);
		repeat (8) @(negedge clk_sys_in);
		chk({10'h000, c}, {10'h000, st.code}, "code");
		chk({14'h0000, ua != 15'h0000}, {14'h0000, st.active}, "active");
		chk(ua, led_a, "led a");
		chk(ua, led_b, "led b");
		chk(ua, led_c, "led c");
		chk(ua, led_d, "led d");
	endtask : lvl
	task automatic t_burst();
		host.pulses(32, 20);
		lvl(5'h1F, 15'h4E20);
		chk(15'h0001, {14'h0000, st.soft_start}, "soft");
	endtask : t_burst
	task automatic t_down();
		host.pulses(31, 20);
		lvl(5'h1E, 15'h458C);
		chk(15'h0000, {14'h0000, st.soft_start}, "soft end");
		host.pulses(2, 20);
		lvl(5'h00, 15'h0225);
	endtask : t_down
	task automatic t_slow();
		host.pulses(1, 45);
		lvl(5'h01, 15'h0273);
	endtask : t_slow
	task automatic t_off();
		host.idle(60);
		lvl(5'h00, 15'h0000);
		host.pulses(1, 20);
		lvl(5'h00, 15'h0225);
	endtask : t_off
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		error_cnt = 0;
		tests_run = 0;
		srst_in = 1'b1;
		repeat (10) @(negedge clk_sys_in);
		srst_in = 1'b0;
		t_burst();
		t_down();
		t_slow();
		t_off();
		wrap_up();
	end
	initial begin
		repeat (9000) @(posedge clk_sys_in);
		error_cnt++;
		wrap_up();
	end
endmodule : tb

`default_nettype wire
